// ==== core/soag_addr_gen.sv ====
// Operand address generator: segment choice, offsets, I/O ports, pushes.
`timescale 1ns/1ps
`default_nettype none
module soag_addr_gen
   import soag_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire soag_req_t   req,
   input  wire soag_regs_t  regs,
   output soag_addr_t       addrOut,
   output logic      [19:0] addrPhysQ,
   // Far pointer load.
   input  wire logic        farLoad,
   input  wire logic [31:0] farPtr,
   input  wire logic [1:0]  farSegSel,
   output logic      [15:0] farSeg,
   output logic      [15:0] farOffset,
   output logic      [1:0]  farSegIdx,
   output logic             farValid,
   // Register operand access.
   input  wire logic [2:0]  regSel,
   input  wire logic        regByte,
   input  wire logic [127:0] genRegs,
   output logic      [15:0] regOperand,
   // Data type helpers.
   input  wire logic [15:0] typeVal,
   input  wire logic        typeByte,
   output logic             typeNeg,
   output logic      [15:0] typeSext,
   output logic             bcdPackedOk,
   output logic             bcdUnpackedOk,
   input  wire logic [16:0] strLen,
   output logic             strLenOk,
   // Interrupt entry.
   input  wire logic        intEnter,
   input  wire soag_intc_t  intClass,
   output logic             pushValid,
   output logic      [15:0] pushData,
   output logic      [15:0] pushOffset,
   output logic             pushBusy,
   output logic             intMaskable
);

   logic        useBase;
   logic        useIdx;
   soag_disp_t  effDisp;
   logic [15:0] baseVal;
   logic [15:0] idxVal;
   logic [15:0] eaOffset;
   logic [1:0]  implSeg;
   logic [1:0]  selSeg;
   logic [15:0] segVal;
   logic [15:0] ioPort;
   logic [19:0] phys;

   // Only the two base and the two index registers are reachable.
   assign baseVal = req.baseIsPtr ? regs.basePtrReg : regs.baseReg;
   assign idxVal  = req.idxIsDest ? regs.destIdxReg : regs.srcIdxReg;

   always_comb begin
      useBase = 1'b0;
      useIdx  = 1'b0;
      effDisp = req.dispSize;
      case (req.mode)
         MODE_DIRECT: begin
            effDisp = (req.dispSize == DISP_NONE) ? DISP_16 : req.dispSize;
         end
         MODE_REGIND: begin
            useBase = ~req.regIndIsIdx;
            useIdx  = req.regIndIsIdx;
            effDisp = DISP_NONE;
         end
         MODE_BASED:   useBase = 1'b1;
         MODE_INDEXED: useIdx = 1'b1;
         MODE_BIDX: begin
            useBase = 1'b1;
            useIdx  = 1'b1;
            effDisp = DISP_NONE;
         end
         MODE_BIDXD: begin
            useBase = 1'b1;
            useIdx  = 1'b1;
         end
         default: effDisp = DISP_NONE;
      endcase
   end

   soag_ea_adder u_adder (
      .useBase  (useBase),
      .useIdx   (useIdx),
      .dispSize (effDisp),
      .baseVal  (baseVal),
      .idxVal   (idxVal),
      .disp     (req.disp),
      .offset   (eaOffset)
   );

   // Implicit segment choice by reference kind.
   always_comb begin
      case (req.kind)
         REF_FETCH:  implSeg = SEG_CODE;
         REF_STACK:  implSeg = SEG_STACK;
         REF_STRDST: implSeg = SEG_EXTRA;
         default: begin
            if (useBase && req.baseIsPtr) begin
               implSeg = SEG_STACK;
            end else begin
               implSeg = SEG_DATA;
            end
         end
      endcase
   end

   // Override touches only the memory operand and the source string; fetch, stack and the
   // destination string stream keep their fixed segment.
   assign selSeg = (req.ovrValid && (req.kind == REF_DATA ||
                    req.kind == REF_STRSRC)) ? req.ovrSeg : implSeg;

   always_comb begin
      case (selSeg)
         SEG_CODE:  segVal = regs.codeSeg;
         SEG_STACK: segVal = regs.stackSeg;
         SEG_EXTRA: segVal = regs.extraSeg;
         default:   segVal = regs.dataSeg;
      endcase
   end

   assign phys = PHYS_W'({segVal, 4'h0}) + PHYS_W'(eaOffset);

   // Port address: full 16 bits give 64K byte or 32K word ports.
   assign ioPort = req.ioImm ? {8'h00, req.ioPort8} : regs.portPtrReg;

   // Same-cycle answer to the bus unit.
   always_comb begin
      addrOut.valid      = req.valid;
      addrOut.isIo       = req.kind == REF_IO;
      addrOut.seg        = (req.kind == REF_IO) ? SEG_DATA : selSeg;
      addrOut.offset     = (req.kind == REF_IO) ? ioPort : eaOffset;
      addrOut.phys       = (req.kind == REF_IO) ? {4'h0, ioPort} : phys;
      // Flag only; placing devices there is the system's concern.
      addrOut.ioReserved = (req.kind == REF_IO) && ioPort >= IO_RSV_LO &&
                           ioPort <= IO_RSV_HI;
   end

   // Registered copy of the last physical address.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         addrPhysQ <= 20'h00000;
      end else if (req.valid) begin
         addrPhysQ <= addrOut.phys;
      end
   end

   // Far pointer: low word offset, high word segment.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         farSeg    <= RESET_WORD;
         farOffset <= RESET_WORD;
         farSegIdx <= SEG_DATA;
         farValid  <= 1'b0;
      end else begin
         farValid <= farLoad;
         if (farLoad) begin
            farOffset <= farPtr[15:0];
            farSeg    <= farPtr[31:16];
            farSegIdx <= farSegSel;
         end
      end
   end

   // Register operand: AL..BH halves for byte, whole register for word.
   logic [15:0] regWords [8];
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_regs
         assign regWords[gi] = genRegs[gi*16 +: 16];
      end
   endgenerate

   always_comb begin
      if (regByte) begin
         regOperand = regSel[2] ? {8'h00, regWords[regSel[1:0]][15:8]}
                                : {8'h00, regWords[regSel[1:0]][7:0]};
      end else begin
         regOperand = regWords[regSel];
      end
   end

   // Data type helpers.
   assign typeNeg  = typeByte ? typeVal[7] : typeVal[15];
   assign typeSext = typeByte ? {{8{typeVal[7]}}, typeVal[7:0]} : typeVal;
   assign bcdPackedOk = typeVal[7:4] <= BCD_MAX &&
                        typeVal[3:0] <= BCD_MAX;
   assign bcdUnpackedOk = typeVal[7:0] <= {4'h0, BCD_MAX};
   assign strLenOk = strLen != 17'h00000 && strLen <= 17'h10000;

   // Hardware maskable class only is subject to the enable flag.
   assign intMaskable = intEnter && intClass == INTC_HW_MASK;

   // Interrupt entry push sequencer.
   typedef enum logic [1:0] {
      PS_IDLE = 2'b00,
      PS_FLAG = 2'b01,
      PS_CSEG = 2'b10,
      PS_IPTR = 2'b11
   } soag_push_t;

   soag_push_t  pushSt_r;
   soag_push_t  pushSt_nxt;
   logic [15:0] sp_r;
   logic [15:0] savCs_r;
   logic [15:0] savIp_r;
   logic [15:0] savSw_r;

   always_comb begin
      case (pushSt_r)
         PS_IDLE: pushSt_nxt = intEnter ? PS_FLAG : PS_IDLE;
         PS_FLAG: pushSt_nxt = PS_CSEG;
         PS_CSEG: pushSt_nxt = PS_IPTR;
         PS_IPTR: pushSt_nxt = PS_IDLE;
         default: pushSt_nxt = PS_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pushSt_r <= PS_IDLE;
      end else begin
         pushSt_r <= pushSt_nxt;
      end
   end

   // State is captured at entry so that later updates cannot corrupt it.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         savCs_r <= RESET_WORD;
         savIp_r <= RESET_WORD;
         savSw_r <= RESET_WORD;
         sp_r    <= RESET_WORD;
      end else if (pushSt_r == PS_IDLE && intEnter) begin
         savCs_r <= regs.codeSeg;
         savIp_r <= regs.instrPtr;
         savSw_r <= regs.statusWord;
         sp_r    <= RESET_WORD;
      end else if (pushSt_r != PS_IDLE) begin
         sp_r <= 16'(sp_r - 16'h0002);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pushValid  <= 1'b0;
         pushData   <= RESET_WORD;
         pushOffset <= RESET_WORD;
      end else begin
         pushValid  <= pushSt_r != PS_IDLE;
         pushOffset <= 16'(sp_r - 16'h0002);
         case (pushSt_r)
            PS_FLAG: pushData <= savSw_r;
            PS_CSEG: pushData <= savCs_r;
            PS_IPTR: pushData <= savIp_r;
            default: pushData <= pushData;
         endcase
      end
   end

   assign pushBusy = pushSt_r != PS_IDLE;

   // Checks.
   property p_fetch_code;
      @(posedge clk) disable iff (rst)
      (req.valid && req.kind == REF_FETCH) |-> addrOut.seg == SEG_CODE;
   endproperty
   a_fetch_code: assert property (p_fetch_code) else $error("fetch seg");

   property p_bp_stack;
      @(posedge clk) disable iff (rst)
      (req.valid && req.kind == REF_DATA && !req.ovrValid && useBase &&
       req.baseIsPtr) |-> addrOut.seg == SEG_STACK;
   endproperty
   a_bp_stack: assert property (p_bp_stack) else $error("bp seg");

   property p_strdst_extra;
      @(posedge clk) disable iff (rst)
      (req.valid && req.kind == REF_STRDST) |-> addrOut.seg == SEG_EXTRA;
   endproperty
   a_strdst_extra: assert property (p_strdst_extra) else $error("es seg");

   property p_override;
      @(posedge clk) disable iff (rst)
      (req.valid && req.kind == REF_DATA && req.ovrValid)
         |-> addrOut.seg == req.ovrSeg;
   endproperty
   a_override: assert property (p_override) else $error("override");

   property p_direct;
      @(posedge clk) disable iff (rst)
      (req.valid && req.kind == REF_DATA && req.mode == MODE_DIRECT &&
       req.dispSize == DISP_16) |-> addrOut.offset == req.disp;
   endproperty
   a_direct: assert property (p_direct) else $error("direct offset");

   property p_io_imm;
      @(posedge clk) disable iff (rst)
      (req.valid && req.kind == REF_IO && req.ioImm)
         |-> addrOut.offset[15:8] == 8'h00;
   endproperty
   a_io_imm: assert property (p_io_imm) else $error("io zext");

   property p_phys;
      @(posedge clk) disable iff (rst)
      (req.valid && req.kind != REF_IO) |->
         addrOut.phys == PHYS_W'({segVal, 4'h0}) + PHYS_W'(addrOut.offset);
   endproperty
   a_phys: assert property (p_phys) else $error("phys address");

   property p_push_seq;
      @(posedge clk) disable iff (rst)
      (pushSt_r == PS_IDLE && intEnter) |=> ##1
         (pushValid && pushData == $past(regs.statusWord, 2)) ##1
         (pushValid && pushData == $past(regs.codeSeg, 3)) ##1
         (pushValid && pushData == $past(regs.instrPtr, 4));
   endproperty
   a_push_seq: assert property (p_push_seq) else $error("push order");

   c_override: cover property (@(posedge clk) disable iff (rst)
      req.valid && req.ovrValid);
   c_bidxd: cover property (@(posedge clk) disable iff (rst)
      req.valid && req.mode == MODE_BIDXD && req.dispSize == DISP_8);
   c_io_rsv: cover property (@(posedge clk) disable iff (rst)
      addrOut.ioReserved);
   c_push: cover property (@(posedge clk) disable iff (rst)
      pushValid ##1 pushValid ##1 pushValid);

endmodule
`default_nettype wire

// ==== core/soag_ea_adder.sv ====
// Effective offset adder: sign extension and modulo 16-bit sum.
`timescale 1ns/1ps
`default_nettype none
module soag_ea_adder
   import soag_pkg::*;
(
   input  wire logic        useBase,
   input  wire logic        useIdx,
   input  wire soag_disp_t  dispSize,
   input  wire logic [15:0] baseVal,
   input  wire logic [15:0] idxVal,
   input  wire logic [15:0] disp,
   output logic      [15:0] offset
);

   logic [15:0] dispExt;
   logic [15:0] baseTerm;
   logic [15:0] idxTerm;

   always_comb begin
      case (dispSize)
         DISP_8:  dispExt = {{8{disp[7]}}, disp[7:0]};
         DISP_16: dispExt = disp;
         default: dispExt = 16'h0000;
      endcase
   end

   assign baseTerm = useBase ? baseVal : 16'h0000;
   assign idxTerm  = useIdx ? idxVal : 16'h0000;
   // Carry out of bit 15 is dropped by the 16-bit target width.
   assign offset = 16'(baseTerm + idxTerm + dispExt);

endmodule
`default_nettype wire

// ==== inc/soag_pkg.sv ====
// Shared constants and carrier types for the operand address generator.
`default_nettype none
package soag_pkg;

   localparam int unsigned WORD_W   = 16;
   localparam int unsigned PHYS_W   = 20;
   localparam int unsigned SEG_SHIFT = 4;

   // Segment register indices presented to the bus interface unit.
   localparam logic [1:0] SEG_EXTRA = 2'h0;
   localparam logic [1:0] SEG_CODE  = 2'h1;
   localparam logic [1:0] SEG_STACK = 2'h2;
   localparam logic [1:0] SEG_DATA  = 2'h3;

   localparam logic [15:0] IO_RSV_LO  = 16'h00F8;
   localparam logic [15:0] IO_RSV_HI  = 16'h00FF;
   localparam logic [15:0] RESET_WORD = 16'h0000;
   localparam logic [3:0]  BCD_MAX    = 4'h9;
   localparam int unsigned PUSH_WORDS = 3;

   // Reference kinds from the decoder.
   typedef enum logic [2:0] {
      REF_FETCH  = 3'b000,
      REF_STACK  = 3'b001,
      REF_DATA   = 3'b010,
      REF_STRSRC = 3'b011,
      REF_STRDST = 3'b100,
      REF_IO     = 3'b101
   } soag_ref_t;

   // Memory addressing mode.
   typedef enum logic [2:0] {
      MODE_DIRECT  = 3'b000,
      MODE_REGIND  = 3'b001,
      MODE_BASED   = 3'b010,
      MODE_INDEXED = 3'b011,
      MODE_BIDX    = 3'b100,
      MODE_BIDXD   = 3'b101
   } soag_mode_t;

   typedef enum logic [1:0] {
      DISP_NONE = 2'b00,
      DISP_8    = 2'b01,
      DISP_16   = 2'b10
   } soag_disp_t;

   // Interrupt classes.
   typedef enum logic [1:0] {
      INTC_HW_MASK = 2'b00,
      INTC_HW_NMI  = 2'b01,
      INTC_SOFT    = 2'b10,
      INTC_EXCEPT  = 2'b11
   } soag_intc_t;

   // Operand request from the decoder.
   typedef struct packed {
      logic        valid;
      soag_ref_t   kind;
      soag_mode_t  mode;
      logic        baseIsPtr;   // base_pointer_reg, else base_reg
      logic        idxIsDest;   // dest_index_reg, else source index
      logic        regIndIsIdx; // register indirect uses an index reg
      soag_disp_t  dispSize;
      logic [15:0] disp;
      logic        ovrValid;
      logic [1:0]  ovrSeg;
      logic        ioImm;       // port from 8-bit immediate
      logic [7:0]  ioPort8;
   } soag_req_t;

   // Register values the address forming needs.
   typedef struct packed {
      logic [15:0] baseReg;
      logic [15:0] basePtrReg;
      logic [15:0] srcIdxReg;
      logic [15:0] destIdxReg;
      logic [15:0] portPtrReg;
      logic [15:0] codeSeg;
      logic [15:0] stackSeg;
      logic [15:0] dataSeg;
      logic [15:0] extraSeg;
      logic [15:0] instrPtr;
      logic [15:0] statusWord;
   } soag_regs_t;

   // Result to the bus interface unit.
   typedef struct packed {
      logic        valid;
      logic        isIo;
      logic [1:0]  seg;
      logic [15:0] offset;
      logic [19:0] phys;
      logic        ioReserved;
   } soag_addr_t;

endpackage
`default_nettype wire

// ==== testbench/soag_partner_model.sv ====
// Decoder and bus unit stand-in: register values out, pushed words captured.
`timescale 1ns/1ps
`default_nettype none
module soag_partner_model
   import soag_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        pushValid,
   input  wire logic [15:0] pushData,
   input  wire logic [15:0] pushOffset,
   output soag_regs_t       regs,
   output int               pushCount,
   output logic [7:0][31:0] pushLog
);
   // Segment values are kept small so no physical sum overflows 20 bits.
   always_comb begin
      regs.baseReg    = 16'h1000;
      regs.basePtrReg = 16'h2000;
      regs.srcIdxReg  = 16'h0300;
      regs.destIdxReg = 16'h0040;
      regs.portPtrReg = 16'h1234;
      regs.codeSeg    = 16'h1100;
      regs.stackSeg   = 16'h2200;
      regs.dataSeg    = 16'h3300;
      regs.extraSeg   = 16'h4400;
      regs.instrPtr   = 16'h0ABC;
      regs.statusWord = 16'h0202;
   end

   // The bus unit takes every offered word at once; it never stalls a push.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pushCount <= 0;
      end else if (pushValid) begin
         pushLog[pushCount[2:0]] <= {pushOffset, pushData};
         pushCount <= pushCount + 1;
      end
   end
endmodule
`default_nettype wire

// ==== testbench/test_soag_addr_gen.sv ====
// Self-checking bench for the operand address generator.
`timescale 1ns/1ps
`default_nettype none
module test_soag_addr_gen;
   import soag_pkg::*;
   logic clk, rst, farLoad, farValid, regByte, typeByte, typeNeg;
   logic bcdPackedOk, bcdUnpackedOk, strLenOk, intEnter, pushValid;
   logic pushBusy, intMaskable;
   soag_req_t req;
   soag_regs_t regs;
   soag_addr_t addrOut;
   soag_intc_t intClass;
   logic [19:0] addrPhysQ;
   logic [31:0] farPtr;
   logic [1:0] farSegSel, farSegIdx;
   logic [15:0] farSeg, farOffset, regOperand, typeVal, typeSext;
   logic [15:0] pushData, pushOffset;
   logic [2:0] regSel;
   logic [127:0] genRegs;
   logic [16:0] strLen;
   logic [7:0][31:0] pushLog;
   int pushCount, n_fail, cmp_count, cyc;

   soag_addr_gen soag_addr_gen_i (.clk(clk), .rst(rst), .req(req),
      .regs(regs), .addrOut(addrOut), .addrPhysQ(addrPhysQ),
      .farLoad(farLoad), .farPtr(farPtr), .farSegSel(farSegSel),
      .farSeg(farSeg), .farOffset(farOffset), .farSegIdx(farSegIdx),
      .farValid(farValid), .regSel(regSel), .regByte(regByte),
      .genRegs(genRegs), .regOperand(regOperand), .typeVal(typeVal),
      .typeByte(typeByte), .typeNeg(typeNeg), .typeSext(typeSext),
      .bcdPackedOk(bcdPackedOk), .bcdUnpackedOk(bcdUnpackedOk),
      .strLen(strLen), .strLenOk(strLenOk), .intEnter(intEnter),
      .intClass(intClass), .pushValid(pushValid), .pushData(pushData),
      .pushOffset(pushOffset), .pushBusy(pushBusy),
      .intMaskable(intMaskable));

   soag_partner_model soag_partner_model_i (.clk(clk), .rst(rst),
      .pushValid(pushValid), .pushData(pushData), .pushOffset(pushOffset),
      .regs(regs), .pushCount(pushCount), .pushLog(pushLog));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic step();
      @(posedge clk);
      #2;
   endtask

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Flags f are {baseIsPtr, idxIsDest, regIndIsIdx}; ov is {ovrValid, ovrSeg}.
   // Bit 16 of eo says whether the offset is known and compared.
   task automatic acase(input soag_ref_t k, input soag_mode_t m,
      input logic [2:0] f, input soag_disp_t ds, input logic [15:0] d,
      input logic [2:0] ov, input logic [1:0] es, input logic [16:0] eo);
      logic [15:0] sv;
      logic [19:0] ph;
      req = '0;
      req.valid = 1'b1;
      req.kind = k;
      req.mode = m;
      {req.baseIsPtr, req.idxIsDest, req.regIndIsIdx} = f;
      req.dispSize = ds;
      req.disp = d;
      {req.ovrValid, req.ovrSeg} = ov;
      #1;
      sv = es == SEG_EXTRA ? 16'h4400 : es == SEG_CODE ? 16'h1100 :
           es == SEG_STACK ? 16'h2200 : 16'h3300;
      ph = {sv, 4'h0} + {4'h0, eo[15:0]};
      chk("seg", {30'h0, es}, {30'h0, addrOut.seg});
      chk("valid", 32'h1, {31'h0, addrOut.valid});
      if (eo[16]) begin
         chk("offset", {16'h0, eo[15:0]}, {16'h0, addrOut.offset});
         chk("phys", {12'h0, ph}, {12'h0, addrOut.phys});
         step();
         chk("physq", {12'h0, ph}, {12'h0, addrPhysQ});
      end else begin
         step();
      end
   endtask

   task automatic test_segments_offsets();
      acase(REF_FETCH, MODE_DIRECT, 3'b000, DISP_16, 16'h0010, 3'b000,
            SEG_CODE, 17'h10010);
      acase(REF_STACK, MODE_REGIND, 3'b100, DISP_NONE, 16'h0, 3'b000,
            SEG_STACK, 17'h12000);
      acase(REF_DATA, MODE_BASED, 3'b100, DISP_8, 16'h0005, 3'b000,
            SEG_STACK, 17'h12005);
      acase(REF_DATA, MODE_BASED, 3'b000, DISP_16, 16'hF800, 3'b000,
            SEG_DATA, 17'h10800);
      acase(REF_STRDST, MODE_REGIND, 3'b011, DISP_NONE, 16'h0, 3'b000,
            SEG_EXTRA, 17'h10040);
      acase(REF_STRSRC, MODE_REGIND, 3'b001, DISP_NONE, 16'h0, 3'b000,
            SEG_DATA, 17'h10300);
      acase(REF_DATA, MODE_DIRECT, 3'b000, DISP_8, 16'h0080, 3'b000,
            SEG_DATA, 17'h1FF80);
      acase(REF_DATA, MODE_DIRECT, 3'b000, DISP_16, 16'h8001, 3'b000,
            SEG_DATA, 17'h18001);
      acase(REF_DATA, MODE_INDEXED, 3'b000, DISP_8, 16'h00FE, 3'b000,
            SEG_DATA, 17'h102FE);
      acase(REF_DATA, MODE_BIDX, 3'b010, DISP_NONE, 16'h0, 3'b000,
            SEG_DATA, 17'h11040);
      acase(REF_DATA, MODE_BIDXD, 3'b100, DISP_16, 16'h0100, 3'b000,
            SEG_STACK, 17'h12400);
      acase(REF_DATA, MODE_BIDXD, 3'b010, DISP_8, 16'h00F0, 3'b000,
            SEG_DATA, 17'h11030);
      acase(REF_DATA, MODE_BASED, 3'b100, DISP_8, 16'h0000, {1'b1, SEG_EXTRA},
            SEG_EXTRA, 17'h12000);
      acase(REF_STRSRC, MODE_REGIND, 3'b001, DISP_NONE, 16'h0,
            {1'b1, SEG_CODE}, SEG_CODE, 17'h10300);
      acase(REF_STACK, MODE_REGIND, 3'b100, DISP_NONE, 16'h0,
            {1'b1, SEG_DATA}, SEG_STACK, 17'h12000);
   endtask

   task automatic test_io();
      logic [15:0] ports [4];
      ports = '{16'h00F7, 16'h00F8, 16'h00FF, 16'h00F9};
      for (int i = 0; i < 4; i++) begin
         req = '0;
         req.valid = 1'b1;
         req.kind = REF_IO;
         req.ioImm = 1'b1;
         req.ioPort8 = ports[i][7:0];
         #1;
         chk("io phys", {16'h0, ports[i]}, {12'h0, addrOut.phys});
         chk("io flag", 32'h1, {31'h0, addrOut.isIo});
         chk("io off", {16'h0, ports[i]}, {16'h0, addrOut.offset});
         chk("io seg", 32'h3, {30'h0, addrOut.seg});
         chk("io rsv", {31'h0, i != 0}, {31'h0, addrOut.ioReserved});
         step();
      end
      req.ioImm = 1'b0;
      #1;
      chk("io ptr", 32'h01234, {12'h0, addrOut.phys});
      chk("io rsv", 32'h0, {31'h0, addrOut.ioReserved});
      step();
      req = '0;
   endtask

   task automatic test_far();
      for (int i = 0; i < 4; i++) begin
         farLoad = 1'b1;
         farPtr = {16'h5000 + 16'(i), 16'hA000 + 16'(i)};
         farSegSel = 2'(i);
         step();
         chk("far valid", 32'h1, {31'h0, farValid});
         chk("far seg", 32'h5000 + i, {16'h0, farSeg});
         chk("far off", 32'hA000 + i, {16'h0, farOffset});
         chk("far idx", i, {30'h0, farSegIdx});
      end
      farLoad = 1'b0;
      step();
      chk("far valid", 32'h0, {31'h0, farValid});
      chk("far held", 32'h5003, {16'h0, farSeg});
   endtask

   task automatic test_reg_operands();
      logic [15:0] r;
      for (int i = 0; i < 8; i++) begin
         genRegs[16*i+:16] = {8'hA0 + 8'(i), 8'h50 + 8'(i)};
      end
      for (int i = 0; i < 16; i++) begin
         regSel = 3'(i);
         regByte = i[3];
         r = genRegs[16*(i[3] ? i % 4 : i % 8)+:16];
         #1;
         if (i[3]) begin
            r = {8'h0, i[2] ? r[15:8] : r[7:0]};
         end
         chk("reg operand", {16'h0, r}, {16'h0, regOperand});
         step();
      end
   endtask

   task automatic test_types();
      logic [15:0] tv [5];
      logic [16:0] sl [5];
      tv = '{16'h0080, 16'h007F, 16'h0099, 16'h0009, 16'h009A};
      sl = '{17'h0, 17'h1, 17'h10000, 17'h10001, 17'hFFFF};
      for (int i = 0; i < 5; i++) begin
         typeVal = tv[i];
         typeByte = 1'b1;
         strLen = sl[i];
         #1;
         chk("neg", {31'h0, tv[i][7]}, {31'h0, typeNeg});
         chk("sext", {16'h0, {8{tv[i][7]}}, tv[i][7:0]},
             {16'h0, typeSext});
         chk("packed", {31'h0, tv[i][7:4] <= 4'h9 && tv[i][3:0] <= 4'h9},
             {31'h0, bcdPackedOk});
         chk("unpacked", {31'h0, tv[i][7:0] <= 8'h09},
             {31'h0, bcdUnpackedOk});
         chk("strlen", {31'h0, i != 0 && i != 3}, {31'h0, strLenOk});
         typeByte = 1'b0;
         typeVal = {tv[i][7:0], 8'h00};
         #1;
         chk("neg word", {31'h0, tv[i][7]}, {31'h0, typeNeg});
         chk("sext word", {16'h0, tv[i][7:0], 8'h0}, {16'h0, typeSext});
         step();
      end
   endtask

   task automatic test_interrupts();
      int b;
      logic [31:0] e [3];
      e = '{{16'hFFFE, 16'h0202}, {16'hFFFC, 16'h1100}, {16'hFFFA, 16'h0ABC}};
      for (int c = 0; c < 4; c++) begin
         b = pushCount;
         intClass = soag_intc_t'(c);
         intEnter = 1'b1;
         #1;
         chk("maskable", {31'h0, c == 0}, {31'h0, intMaskable});
         step();
         #1;
         chk("busy", 32'h1, {31'h0, pushBusy});
         step();
         intEnter = 1'b0;
         repeat (6) step();
         chk("maskable idle", 32'h0, {31'h0, intMaskable});
         chk("busy idle", 32'h0, {31'h0, pushBusy});
         chk("push count", b + 3, pushCount);
         for (int k = 0; k < 3; k++) begin
            chk("push word", e[k], pushLog[(b + k) % 8]);
         end
      end
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         give_verdict();
      end
   end

   initial begin
      rst = 1'b1;
      req = '0;
      farLoad = 1'b0;
      farPtr = '0;
      farSegSel = '0;
      regSel = '0;
      regByte = 1'b0;
      genRegs = '0;
      typeVal = '0;
      typeByte = 1'b0;
      strLen = '0;
      intEnter = 1'b0;
      intClass = INTC_HW_MASK;
      repeat (10) @(posedge clk);
      #2;
      rst = 1'b0;
      chk("reset idx", 32'h3, {30'h0, farSegIdx});
      chk("reset push", 32'h0, {31'h0, pushValid});
      step();
      test_segments_offsets();
      test_io();
      test_far();
      test_reg_operands();
      test_types();
      test_interrupts();
      give_verdict();
   end
endmodule
`default_nettype wire
